// ===== common/bos_regs.vh
/*
 * constants for the brake / overtravel sequencer: setting defaults,
 * ranges and timing counts. assumes a 20 MHz system clock.
 */
`ifndef BOS_REGS_VH
`define BOS_REGS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define BOS_CLK_HZ          20000000
`define BOS_TICK_MS         10
`define BOS_TICK_CYC        ((`BOS_CLK_HZ / 1000) * `BOS_TICK_MS)
`define BOS_STATIC_RPM_X10  16'd200

// ----------------------------------------------------------------------
// setting ranges and defaults
// ----------------------------------------------------------------------
`define BOS_OFFDLY_MAX      9'd500
`define BOS_OFFDLY_DEF      9'd0
`define BOS_BRKTHR_MAX      15'd30000
`define BOS_BRKTHR_DEF      15'd1000
`define BOS_BRKDLY_MIN      7'd10
`define BOS_BRKDLY_MAX      7'd100
`define BOS_BRKDLY_DEF      7'd50
`define BOS_STOPTQ_MIN      9'd1
`define BOS_STOPTQ_MAX      9'd300
`define BOS_STOPTQ_DEF      9'd100
`define BOS_DIR_DEF         1'b1
`define BOS_INH_DEF         1'b1
`define BOS_TQMODE_DEF      1'b1

`endif

// ===== logic/bos_sequencer.v
/*
 * brake and hardware overtravel sequencer: brake timing against enable
 * and alarm, direction select, limit inhibits and stop-torque clamp.
 * assumes speed feedback in 0.1 r/min signed units, limit and enable
 * pins asynchronous, alarms and settings synchronous to clk.
 */
// Contract
// - direction_select 1 means counterclockwise is forward, 0 clockwise.
// - below 20 r/min the motor is static, above it running.
// - one dedicated output alone drives the holding brake.
// - brake speed threshold 0..30000 in 0.1 r/min, default 1000; the code compares the setting as given and does not clamp it to 30000.
// - enable off at low speed: brake engages, disable after servo-off delay.
// - forcing alarms disable at once, skipping the servo-off delay.
// - brake-stop delay 10..100 in 10 ms steps, default 50.
// - alarm above threshold disables at once, motor coasts without torque.
// - after disable at speed, brake at threshold or brake-stop delay.
// - active limit zeroes command toward it, opposite direction untouched.
// - forward inhibit enable 0 ignores, 1 honours, default 1.
// - limit inputs are normally closed; open input means inhibit.
// - overtravel off when both enables 0 or no terminals assigned.
// - during limit or e-stop clamp stop torque, 1..300 %, default 100.
// - stop-torque mode 0 uses configured torque, 1 gives zero limit.
`timescale 1ns/10ps
`include "bos_regs.vh"

module bos_sequencer
(
	// clock and reset
	input  wire               clk,
	input  wire               rst_b,
	// settings
	input  wire               direction_select,
	input  wire [8:0]         servo_off_delay,
	input  wire [14:0]        brake_speed_thresh,
	input  wire [6:0]         brake_stop_delay,
	input  wire               fwd_inhibit_en,
	input  wire               rev_inhibit_en,
	input  wire               limits_assigned,
	input  wire [8:0]         overtravel_stop_torque,
	input  wire               stop_torque_mode,
	// drive side
	input  wire               enable_pin,
	input  wire               alarm_force,
	input  wire               estop_active,
	input  wire signed [15:0] speed_fb,
	input  wire signed [15:0] speed_cmd,
	// motor side pins
	input  wire               forward_limit_input,
	input  wire               reverse_limit_input,
	// outputs
	output reg                brake_release,
	output reg                drive_energized,
	output reg                drive_torque_on,
	output reg                motor_running,
	output reg                fwd_inhibit_act,
	output reg                rev_inhibit_act,
	output reg signed [15:0]  speed_cmd_out,
	output reg  [8:0]         torque_limit
);

// ----------------------------------------------------------------------
// states
// ----------------------------------------------------------------------
localparam [3:0] ST_OFF  = 4'b0001;
localparam [3:0] ST_RUN  = 4'b0010;
localparam [3:0] ST_HOLD = 4'b0100;
localparam [3:0] ST_COAST = 4'b1000;

// count held full width, then cut on purpose to the counter's 21 bits
localparam [31:0] TICK_FULL = `BOS_TICK_CYC - 1;
localparam [20:0] TICK_LAST = TICK_FULL[20:0];

// clamp a setting into its range, used for each delay and torque
function [8:0] clamp9;
	input [8:0] v;
	input [8:0] lo;
	input [8:0] hi;
	begin
		if (v < lo)
			clamp9 = lo;
		else if (v > hi)
			clamp9 = hi;
		else
			clamp9 = v;
	end
endfunction

// magnitude of a signed speed, used for feedback and threshold checks
function [15:0] mag16;
	input signed [15:0] v;
	begin
		if (v < 0)
			mag16 = -v;
		else
			mag16 = v;
	end
endfunction

// ----------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------
reg  [2:0]  en_sync_r;
reg  [2:0]  fl_sync_r;
reg  [2:0]  rl_sync_r;
reg         en_r;
reg         fl_r;
reg         rl_r;

// a change counts only once stages two and three agree
always @(posedge clk)
begin
	if (!rst_b)
	begin
		en_sync_r <= 3'h0;
		fl_sync_r <= 3'h0;
		rl_sync_r <= 3'h0;
		en_r      <= 1'b0;
		fl_r      <= 1'b0;
		rl_r      <= 1'b0;
	end
	else
	begin
		en_sync_r <= {en_sync_r[1:0], enable_pin};
		fl_sync_r <= {fl_sync_r[1:0], forward_limit_input};
		rl_sync_r <= {rl_sync_r[1:0], reverse_limit_input};
		if (en_sync_r[1] == en_sync_r[2])
			en_r <= en_sync_r[2];
		if (fl_sync_r[1] == fl_sync_r[2])
			fl_r <= fl_sync_r[2];
		if (rl_sync_r[1] == rl_sync_r[2])
			rl_r <= rl_sync_r[2];
	end
end

// ----------------------------------------------------------------------
// speed classification
// ----------------------------------------------------------------------
wire [15:0] spd_mag  = mag16(speed_fb);
wire        above_thr = spd_mag > {1'b0, brake_speed_thresh};
wire        running   = spd_mag > `BOS_STATIC_RPM_X10;

// ----------------------------------------------------------------------
// 10 ms tick
// ----------------------------------------------------------------------
reg  [20:0] tick_cnt_r;
reg         tick_r;

always @(posedge clk)
begin
	if (!rst_b)
	begin
		tick_cnt_r <= 21'h0;
		tick_r     <= 1'b0;
	end
	else if (tick_cnt_r == TICK_LAST)
	begin
		tick_cnt_r <= 21'h0;
		tick_r     <= 1'b1;
	end
	else
	begin
		tick_cnt_r <= tick_cnt_r + 21'h1;
		tick_r     <= 1'b0;
	end
end

// ----------------------------------------------------------------------
// brake sequencer
// ----------------------------------------------------------------------
reg  [3:0]  state_r;
reg  [3:0]  state_nxt;
reg  [8:0]  dly_cnt_r;
reg  [8:0]  dly_cnt_nxt;

// delays read live so a changed setting acts at once
wire [8:0]  off_lim = clamp9(servo_off_delay, 9'h0, `BOS_OFFDLY_MAX);
wire [8:0]  brk_lim = clamp9({2'h0, brake_stop_delay},
			     {2'h0, `BOS_BRKDLY_MIN},
			     {2'h0, `BOS_BRKDLY_MAX});

always @*
begin
	state_nxt   = state_r;
	dly_cnt_nxt = dly_cnt_r;
	if (tick_r)
		dly_cnt_nxt = dly_cnt_r + 9'h1;
	case (state_r)
	ST_OFF:
	begin
		if (en_r && !alarm_force)
			state_nxt = ST_RUN;
		dly_cnt_nxt = 9'h0;
	end
	ST_RUN:
	begin
		dly_cnt_nxt = 9'h0;
		if (alarm_force && above_thr)
			state_nxt = ST_COAST;
		else if (alarm_force)
			state_nxt = ST_OFF;
		else if (!en_r && !above_thr)
			state_nxt = ST_HOLD;
		else if (!en_r)
			state_nxt = ST_COAST;
	end
	ST_HOLD:
	begin
		// brake already set; torque kept until the delay runs out
		if (alarm_force)
			state_nxt = ST_OFF;
		else if (en_r)
			state_nxt = ST_RUN;
		else if (dly_cnt_r >= off_lim)
			state_nxt = ST_OFF;
	end
	ST_COAST:
	begin
		if (!above_thr || dly_cnt_r >= brk_lim)
			state_nxt = ST_OFF;
	end
	default:
	begin
		state_nxt   = ST_OFF;
		dly_cnt_nxt = 9'h0;
	end
	endcase
end

always @(posedge clk)
begin
	if (!rst_b)
	begin
		state_r   <= ST_OFF;
		dly_cnt_r <= 9'h0;
	end
	else
	begin
		state_r   <= state_nxt;
		dly_cnt_r <= dly_cnt_nxt;
	end
end

// ----------------------------------------------------------------------
// overtravel
// ----------------------------------------------------------------------
// normally closed: low (open wire) means the limit is reached
wire        ot_on  = limits_assigned &&
		     (fwd_inhibit_en || rev_inhibit_en);
wire        fl_act = ot_on && fwd_inhibit_en && !fl_r;
wire        rl_act = ot_on && rev_inhibit_en && !rl_r;

// command sign is positive for forward; map to shaft sense
wire        cw_pos = !direction_select;
reg signed [15:0] cmd_nxt;
reg  [8:0]  tq_nxt;

always @*
begin
	cmd_nxt = speed_cmd;
	if (fl_act && speed_cmd > 0)
		cmd_nxt = 16'sh0000;
	if (rl_act && speed_cmd < 0)
		cmd_nxt = 16'sh0000;
	if (!state_nxt[1] && !state_nxt[2])
		cmd_nxt = 16'sh0000;
	tq_nxt = `BOS_STOPTQ_MAX;
	if (fl_act || rl_act || estop_active)
	begin
		if (stop_torque_mode)
			tq_nxt = 9'h0;
		else
			tq_nxt = clamp9(overtravel_stop_torque,
					`BOS_STOPTQ_MIN,
					`BOS_STOPTQ_MAX);
	end
end

// ----------------------------------------------------------------------
// registered outputs
// ----------------------------------------------------------------------
always @(posedge clk)
begin
	if (!rst_b)
	begin
		brake_release   <= 1'b0;
		drive_energized <= 1'b0;
		drive_torque_on <= 1'b0;
		motor_running   <= 1'b0;
		fwd_inhibit_act <= 1'b0;
		rev_inhibit_act <= 1'b0;
		speed_cmd_out   <= 16'sh0000;
		torque_limit    <= 9'h0;
	end
	else
	begin
		// coasting keeps the brake open until slow enough or timed out
		brake_release   <= state_nxt[1] || state_nxt[3];
		drive_energized <= state_nxt[1] || state_nxt[2];
		drive_torque_on <= state_nxt[1] || state_nxt[2];
		motor_running   <= running;
		fwd_inhibit_act <= fl_act;
		rev_inhibit_act <= rl_act;
		speed_cmd_out   <= cw_pos ? -cmd_nxt : cmd_nxt;
		torque_limit    <= tq_nxt;
	end
end

endmodule // bos_sequencer

// ===== bench/bos_motor.sv
/* motor with limit switches for the sequencer bench
   assumes speed_cmd_out is already in motor rotation sense */
`timescale 1ns/10ps
module bos_motor
(
	// drive side
	input wire clk, torque_on, fwd_hit, rev_hit,
	input wire signed [15:0] cmd,
	// feedback and switches
	output reg signed [15:0] speed = 16'sh0,
	output wire fwd_lim, rev_lim
);
// ----
// shaft
// ----
// coasting sheds 10 r/min a cycle so the threshold is crossed quickly
always @(posedge clk)
	if (torque_on)
		speed <= cmd;
	else if (speed > 16'sh64)
		speed <= speed - 16'sh64;
	else if (speed < -16'sh64)
		speed <= speed + 16'sh64;
	else
		speed <= 16'sh0;
// closed contacts: a struck switch opens the line
assign fwd_lim = !fwd_hit;
assign rev_lim = !rev_hit;
endmodule // bos_motor

// ===== bench/bos_chk_assertions.sv
/* port assertions for the brake and overtravel sequencer
   assumes binding into every sequencer instance */
`timescale 1ns/10ps
module bos_chk
(
	input wire clk, rst_b, alarm_force, estop_active, stop_torque_mode,
	input wire fwd_inhibit_en, limits_assigned, forward_limit_input,
	input wire direction_select, brake_release, drive_energized,
	input wire drive_torque_on, motor_running, fwd_inhibit_act,
	input wire [8:0] overtravel_stop_torque, torque_limit,
	input wire [14:0] brake_speed_thresh,
	input wire signed [15:0] speed_fb, speed_cmd_out
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
property p_brk; !drive_energized && !$past(brake_release) |->
	!brake_release; endproperty
a_brk: assert property (p_brk) else $error("brake open while off");
property p_run; $past(rst_b, 2) |-> motor_running ==
	($past(speed_fb) > 16'shC8 || $past(speed_fb) < -16'shC8); endproperty
a_run: assert property (p_run) else $error("running flag wrong");
property p_alm; alarm_force |=> !drive_torque_on && !drive_energized;
endproperty
a_alm: assert property (p_alm) else $error("alarm not obeyed");
property p_off; !drive_energized |-> speed_cmd_out == 16'sh0; endproperty
a_off: assert property (p_off) else $error("command while off");
property p_tq0; estop_active && stop_torque_mode |=> torque_limit == 9'h0;
endproperty
a_tq0: assert property (p_tq0) else $error("torque not zero");
property p_tqs; estop_active && !stop_torque_mode &&
	overtravel_stop_torque inside {[9'h1:9'h12C]} |=>
	torque_limit == $past(overtravel_stop_torque); endproperty
a_tqs: assert property (p_tqs) else $error("stop torque wrong");
property p_fen; !fwd_inhibit_en || !limits_assigned |=> !fwd_inhibit_act;
endproperty
a_fen: assert property (p_fen) else $error("inhibit not off");
property p_lim; (!forward_limit_input && fwd_inhibit_en &&
	limits_assigned) [*6] |=> fwd_inhibit_act; endproperty
a_lim: assert property (p_lim) else $error("open limit ignored");
property p_inh; fwd_inhibit_act && $past(fwd_inhibit_act) &&
	direction_select && $past(direction_select) |-> speed_cmd_out <= 0;
endproperty
a_inh: assert property (p_inh) else $error("moved into limit");
property p_cst; brake_release && !drive_energized |->
	$past(speed_fb) > $signed({1'b0, $past(brake_speed_thresh)}) ||
	$past(speed_fb) < -$signed({1'b0, $past(brake_speed_thresh)});
endproperty
a_cst: assert property (p_cst) else $error("brake open when slow");
endmodule // bos_chk
bind bos_sequencer bos_chk bos_chk_i (.clk, .rst_b, .alarm_force,
	.estop_active, .stop_torque_mode, .fwd_inhibit_en, .limits_assigned,
	.forward_limit_input, .direction_select, .brake_release,
	.drive_energized, .drive_torque_on, .motor_running, .fwd_inhibit_act,
	.overtravel_stop_torque, .torque_limit, .speed_fb, .speed_cmd_out,
	.brake_speed_thresh);

// ===== bench/tb.sv
/* self-checking bench for the brake and overtravel sequencer
   assumes the 10 ms tick is never reached in this short run */
`timescale 1ns/10ps
module tb;
// ----
// wiring
// ----
reg clk = 0, rst_b = 0, dir = 1, fen = 1, ren = 1, asg = 1, mode = 1;
reg en = 0, alm = 0, est = 0, fh = 0, rh = 0;
reg [8:0] sod = 9'h0, ots = 9'h064;
reg [14:0] thr = 15'h3E8;
reg [6:0] bsd = 7'h32;
reg signed [15:0] cmd = 16'sh0;
wire signed [15:0] fb, co;
wire fl, rl, br, de, dt, mr, fa, ra;
wire [8:0] tl;
int fail_count = 0, n_compared = 0, cyc = 0;
bos_sequencer bos_sequencer_i (.clk(clk), .rst_b(rst_b),
	.direction_select(dir), .servo_off_delay(sod),
	.brake_speed_thresh(thr), .brake_stop_delay(bsd),
	.fwd_inhibit_en(fen), .rev_inhibit_en(ren), .limits_assigned(asg),
	.overtravel_stop_torque(ots), .stop_torque_mode(mode),
	.enable_pin(en), .alarm_force(alm), .estop_active(est),
	.speed_fb(fb), .speed_cmd(cmd), .forward_limit_input(fl),
	.reverse_limit_input(rl), .brake_release(br), .drive_energized(de),
	.drive_torque_on(dt), .motor_running(mr), .fwd_inhibit_act(fa),
	.rev_inhibit_act(ra), .speed_cmd_out(co), .torque_limit(tl));
bos_motor bos_motor_i (.clk(clk), .torque_on(dt), .cmd(co),
	.fwd_hit(fh), .rev_hit(rh), .speed(fb), .fwd_lim(fl), .rev_lim(rl));
// ----
// helpers
// ----
initial forever #25 clk = ~clk;
task finish_test;
	$display("compared %0d failed %0d", n_compared, fail_count);
	if (fail_count == 0 && n_compared > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
// whole run needs under two hundred cycles
always @(posedge clk)
begin
	cyc = cyc + 1;
	if (cyc == 2000)
	begin
		fail_count++;
		finish_test;
	end
end
task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
	n_compared++;
	if (s !== e)
	begin
		fail_count++;
		$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
	end
endtask
task w(input int n);
	repeat (n) @(posedge clk);
	#1;
endtask
// ----
// tests
// ----
initial
begin
	w(8);
	chk("brake", br, 16'h0);
	@(posedge clk) rst_b <= 1;
	@(posedge clk) begin en <= 1; cmd <= 16'sh1F4; end
	w(10);
	chk("brake", br, 16'h1);
	chk("cmd", co, 16'h1F4);
	chk("run", mr, 16'h1);
	@(posedge clk) dir <= 0;
	w(3);
	chk("cmd", co, -16'sh1F4);
	@(posedge clk) cmd <= 16'shC8;
	w(3);
	chk("run", mr, 16'h0);
	@(posedge clk) begin dir <= 1; cmd <= 16'sh1F4; end
	$display("test run done");
	@(posedge clk) fh <= 1;
	w(8);
	chk("fwd", fa, 16'h1);
	chk("cmd", co, 16'h0);
	@(posedge clk) cmd <= -16'sh1F4;
	w(3);
	chk("cmd", co, -16'sh1F4);
	@(posedge clk) fen <= 0;
	w(3);
	chk("fwd", fa, 16'h0);
	chk("tq", tl, 16'h12C);
	@(posedge clk) begin fen <= 1; rh <= 1; end
	w(8);
	chk("rev", ra, 16'h1);
	@(posedge clk) asg <= 0;
	w(3);
	chk("rev", ra, 16'h0);
	chk("fwd", fa, 16'h0);
	@(posedge clk) begin asg <= 1; fen <= 0; ren <= 0; end
	w(3);
	chk("rev", ra, 16'h0);
	@(posedge clk) begin fh <= 0; rh <= 0; fen <= 1; ren <= 1; end
	@(posedge clk) begin est <= 1; mode <= 0; ots <= 9'h096; end
	w(3);
	chk("tq", tl, 16'h096);
	@(posedge clk) mode <= 1;
	w(3);
	chk("tq", tl, 16'h0);
	@(posedge clk) est <= 0;
	w(3);
	chk("tq", tl, 16'h12C);
	$display("test limits done");
	@(posedge clk) cmd <= 16'sh1F4;
	w(4);
	@(posedge clk) en <= 0;
	w(5);
	chk("brake", br, 16'h0);
	chk("power", de, 16'h1);
	w(3);
	chk("brake", br, 16'h0);
	chk("power", de, 16'h0);
	$display("test stop done");
	@(posedge clk) begin en <= 1; cmd <= 16'sh1F4; end
	w(10);
	@(posedge clk) alm <= 1;
	w(2);
	chk("power", de, 16'h0);
	chk("brake", br, 16'h0);
	@(posedge clk) alm <= 0;
	w(3);
	chk("brake", br, 16'h1);
	$display("test low alarm done");
	@(posedge clk) begin en <= 1; cmd <= 16'shBB8; end
	w(10);
	@(posedge clk) alm <= 1;
	w(2);
	chk("torque", dt, 16'h0);
	chk("brake", br, 16'h1);
	w(10);
	chk("brake", br, 16'h1);
	w(30);
	chk("brake", br, 16'h0);
	chk("power", de, 16'h0);
	$display("test alarm done");
	finish_test;
end
endmodule // tb
